// ---- io_space_params.svh ----
`ifndef IO_SPACE_PARAMS_SVH
`define IO_SPACE_PARAMS_SVH

// ****************************************************************
// Address windows
// ****************************************************************
`define IO_LAST 8'h3F
`define DATA_IO_BASE 8'h20
`define DATA_IO_LAST 8'h5F
`define EXT_FIRST 8'h60
`define BIT_LAST 6'h1F

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_PORT_A_PINS 6'h00
`define OFS_PORT_A_DIR 6'h01
`define OFS_PORT_A_OUT 6'h02
`define OFS_PORT_B_PINS 6'h03
`define OFS_PORT_B_DIR 6'h04
`define OFS_PORT_B_OUT 6'h05
`define OFS_PORT_C_PINS 6'h06
`define OFS_PORT_C_DIR 6'h07
`define OFS_PORT_C_OUT 6'h08
`define OFS_PORT_D_PINS 6'h09
`define OFS_PORT_D_DIR 6'h0A
`define OFS_PORT_D_OUT 6'h0B
`define OFS_PORT_E_PINS 6'h0C
`define OFS_PORT_E_DIR 6'h0D
`define OFS_PORT_E_OUT 6'h0E
`define OFS_PORT_F_PINS 6'h0F
`define OFS_PORT_F_DIR 6'h10
`define OFS_PORT_F_OUT 6'h11
`define OFS_PORT_G_PINS 6'h12
`define OFS_PORT_G_DIR 6'h13
`define OFS_PORT_G_OUT 6'h14
`define OFS_TIMER0_FLAGS 6'h15
`define OFS_TIMER1_FLAGS 6'h16
`define OFS_TIMER2_FLAGS 6'h17
`define OFS_EXT_INT_FLAGS 6'h1C
`define OFS_EXT_INT_MASK 6'h1D
`define OFS_SCRATCH_0 6'h1E
`define OFS_EEPROM_CTRL 6'h1F
`define OFS_EEPROM_DATA 6'h20
`define OFS_EEPROM_ADDR_LO 6'h21
`define OFS_EEPROM_ADDR_HI 6'h22
`define OFS_PRESCALER_CTRL 6'h23
`define OFS_TIMER0_CTRL 6'h24
`define OFS_TIMER0_COUNT 6'h26
`define OFS_TIMER0_COMPARE 6'h27
`define OFS_SCRATCH_1 6'h2A
`define OFS_SCRATCH_2 6'h2B
`define OFS_SPI_CTRL 6'h2C
`define OFS_SPI_STATUS 6'h2D

// ****************************************************************
// Field masks and reset value
// ****************************************************************
`define MASK_FULL 8'hFF
`define MASK_NONE 8'h00
`define MASK_PORT_G 8'h1F
`define MASK_TIMER0_FLAGS 8'h03
`define MASK_TIMER1_FLAGS 8'h27
`define MASK_TIMER2_FLAGS 8'h03
`define MASK_EXT_INT 8'hC3
`define MASK_EEPROM_CTRL 8'h0F
`define MASK_EEPROM_ADDR_HI 8'h01
`define MASK_PRESCALER 8'h83
`define MASK_SPI_STATUS_RW 8'h01
`define MASK_SPI_STATUS_HW 8'hC0
`define RESET_VALUE 8'h00
`endif

// ---- io_space_pkg.sv ----
package io_space_pkg;

    typedef enum logic [2:0] {
        op_read,
        op_write,
        set_single_bit_instr,
        clear_single_bit_instr,
        skip_if_bit_one_instr,
        skip_if_bit_zero_instr
    } io_op_t;

    typedef struct packed {
        logic valid;
        logic data_space;
        io_op_t op;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic valid;
        logic hit;
        logic ext_hit;
        logic refused;
        logic skip;
        logic [7:0] rdata;
    } io_rsp_t;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] d;
        logic [7:0] e;
        logic [7:0] f;
        logic [4:0] g;
    } port_bus_t;

    typedef struct packed {
        logic [7:0] timer0;
        logic [7:0] timer1;
        logic [7:0] timer2;
        logic [7:0] ext_int;
    } flag_event_t;

    typedef struct packed {
        logic [7:0] timer0_event_flags;
        logic [7:0] timer1_event_flags;
        logic [7:0] timer2_event_flags;
        logic [7:0] external_interrupt_flags;
        logic [7:0] external_interrupt_mask;
        logic [7:0] eeprom_control;
        logic [7:0] eeprom_data;
        logic [7:0] eeprom_address_low;
        logic [7:0] eeprom_address_high;
        logic [7:0] timer_prescaler_control;
        logic [7:0] timer0_control;
        logic [7:0] timer0_count;
        logic [7:0] timer0_compare_value;
        logic [7:0] serial_peripheral_control;
        logic [7:0] serial_peripheral_status;
    } periph_ctrl_t;

endpackage

// ---- io_register_space_decoder.sv ----
`timescale 1ns/1ns
`include "io_space_params.svh"

module io_register_space_decoder (
    input wire logic sys_clk,
    input wire logic rst,
    input wire io_space_pkg::io_req_t req,
    output io_space_pkg::io_rsp_t rsp,
    output logic ext_sel,
    input wire io_space_pkg::port_bus_t pins,
    input wire io_space_pkg::flag_event_t flag_set,
    input wire logic [1:0] spi_hw_status,
    output io_space_pkg::port_bus_t port_dir,
    output io_space_pkg::port_bus_t port_out,
    output io_space_pkg::periph_ctrl_t ctrl
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    // Bits that software stores; stored bits outside this and the flag mask read zero
    function automatic logic [7:0] rw_mask(input logic [5:0] a);
        unique case (a)
            `OFS_PORT_A_DIR, `OFS_PORT_A_OUT, `OFS_PORT_B_DIR, `OFS_PORT_B_OUT,
            `OFS_PORT_C_DIR, `OFS_PORT_C_OUT, `OFS_PORT_D_DIR, `OFS_PORT_D_OUT,
            `OFS_PORT_E_DIR, `OFS_PORT_E_OUT, `OFS_PORT_F_DIR, `OFS_PORT_F_OUT,
            `OFS_EXT_INT_MASK, `OFS_SCRATCH_0, `OFS_EEPROM_DATA,
            `OFS_EEPROM_ADDR_LO, `OFS_TIMER0_CTRL, `OFS_TIMER0_COUNT,
            `OFS_TIMER0_COMPARE, `OFS_SCRATCH_1, `OFS_SCRATCH_2,
            `OFS_SPI_CTRL: rw_mask = `MASK_FULL;
            `OFS_PORT_G_DIR, `OFS_PORT_G_OUT: rw_mask = `MASK_PORT_G;
            `OFS_EEPROM_CTRL: rw_mask = `MASK_EEPROM_CTRL;
            `OFS_EEPROM_ADDR_HI: rw_mask = `MASK_EEPROM_ADDR_HI;
            `OFS_PRESCALER_CTRL: rw_mask = `MASK_PRESCALER;
            `OFS_SPI_STATUS: rw_mask = `MASK_SPI_STATUS_RW;
            default: rw_mask = `MASK_NONE;
        endcase
    endfunction

    // Flag bits set by hardware and cleared by writing one
    function automatic logic [7:0] w1c_mask(input logic [5:0] a);
        unique case (a)
            `OFS_TIMER0_FLAGS: w1c_mask = `MASK_TIMER0_FLAGS;
            `OFS_TIMER1_FLAGS: w1c_mask = `MASK_TIMER1_FLAGS;
            `OFS_TIMER2_FLAGS: w1c_mask = `MASK_TIMER2_FLAGS;
            `OFS_EXT_INT_FLAGS: w1c_mask = `MASK_EXT_INT;
            default: w1c_mask = `MASK_NONE;
        endcase
    endfunction

    function automatic logic [7:0] event_bits(input logic [5:0] a);
        unique case (a)
            `OFS_TIMER0_FLAGS: event_bits = flag_set.timer0;
            `OFS_TIMER1_FLAGS: event_bits = flag_set.timer1;
            `OFS_TIMER2_FLAGS: event_bits = flag_set.timer2;
            `OFS_EXT_INT_FLAGS: event_bits = flag_set.ext_int;
            default: event_bits = `MASK_NONE;
        endcase
    endfunction

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic [7:0] store [64];
    logic [7:0] data_ofs;
    logic [5:0] ofs;
    logic in_window;
    logic io_refused;
    logic bit_op;
    logic bit_refused;
    logic take;
    logic wr_en;
    logic [7:0] bit_m;
    logic [7:0] cur;
    logic [7:0] next_val;

    assign data_ofs = req.addr - `DATA_IO_BASE;
    assign bit_op = req.op != io_space_pkg::op_read && req.op != io_space_pkg::op_write;

    always_comb begin
        if (req.data_space) begin
            in_window = req.addr >= `DATA_IO_BASE && req.addr <= `DATA_IO_LAST;
            ofs = data_ofs[5:0];
            io_refused = 1'b0;
        end else begin
            in_window = req.addr <= `IO_LAST;
            ofs = req.addr[5:0];
            io_refused = !in_window;
        end
    end

    // only data-space accesses reach the extended bank
    assign ext_sel = req.valid && req.data_space && req.addr >= `EXT_FIRST && !bit_op;

    // bit operations only from I/O instructions on the low 32
    assign bit_refused = bit_op && (req.data_space || !in_window || ofs > `BIT_LAST);
    assign take = req.valid && in_window && !bit_refused;
    assign wr_en = take && (req.op == io_space_pkg::op_write
        || req.op == io_space_pkg::set_single_bit_instr
        || req.op == io_space_pkg::clear_single_bit_instr);
    assign bit_m = 8'h01 << req.bit_sel;

    // ****************************************************************
    // Read value
    // ****************************************************************
    function automatic logic [7:0] read_value(input logic [5:0] a);
        unique case (a)
            `OFS_PORT_A_PINS: read_value = pins.a;
            `OFS_PORT_B_PINS: read_value = pins.b;
            `OFS_PORT_C_PINS: read_value = pins.c;
            `OFS_PORT_D_PINS: read_value = pins.d;
            `OFS_PORT_E_PINS: read_value = pins.e;
            `OFS_PORT_F_PINS: read_value = pins.f;
            `OFS_PORT_G_PINS: read_value = {3'h0, pins.g};
            `OFS_SPI_STATUS: read_value = {spi_hw_status, 6'h00}
                | (store[a] & `MASK_SPI_STATUS_RW);
            default: read_value = store[a] & (rw_mask(a) | w1c_mask(a));
        endcase
    endfunction

    assign cur = read_value(ofs);

    always_comb begin
        next_val = store[ofs];
        unique case (req.op)
            io_space_pkg::op_write: begin
                next_val = (req.wdata & rw_mask(ofs))
                    | (store[ofs] & w1c_mask(ofs) & ~req.wdata);
            end
            io_space_pkg::set_single_bit_instr: begin
                // the addressed bit alone; a one there clears that flag
                next_val = (store[ofs] | (bit_m & rw_mask(ofs))) & ~(bit_m & w1c_mask(ofs));
            end
            io_space_pkg::clear_single_bit_instr: begin
                // a zero never clears a flag
                next_val = store[ofs] & ~(bit_m & rw_mask(ofs));
            end
            default: next_val = store[ofs];
        endcase
    end

    // ****************************************************************
    // Register storage
    // ****************************************************************
    // Hardware events are OR-ed in last so a set in the clearing cycle wins
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 64; i++) begin
            if (rst) begin
                store[i] <= `RESET_VALUE;
            end else if (wr_en && ofs == 6'(i)) begin
                store[i] <= next_val | (event_bits(6'(i)) & w1c_mask(6'(i)));
            end else begin
                store[i] <= store[i] | (event_bits(6'(i)) & w1c_mask(6'(i)));
            end
        end
    end

    // ****************************************************************
    // Response
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rsp <= '0;
        end else begin
            rsp.valid <= req.valid;
            rsp.hit <= take;
            rsp.ext_hit <= ext_sel;
            rsp.refused <= req.valid && (io_refused || bit_refused);
            rsp.rdata <= (take && req.op == io_space_pkg::op_read) ? cur : 8'h00;
            if (take && req.op == io_space_pkg::skip_if_bit_one_instr) begin
                rsp.skip <= |(cur & bit_m);
            end else if (take && req.op == io_space_pkg::skip_if_bit_zero_instr) begin
                rsp.skip <= ~|(cur & bit_m);
            end else begin
                rsp.skip <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Outputs to the port pads and peripherals
    // ****************************************************************
    assign port_dir.a = store[`OFS_PORT_A_DIR];
    assign port_dir.b = store[`OFS_PORT_B_DIR];
    assign port_dir.c = store[`OFS_PORT_C_DIR];
    assign port_dir.d = store[`OFS_PORT_D_DIR];
    assign port_dir.e = store[`OFS_PORT_E_DIR];
    assign port_dir.f = store[`OFS_PORT_F_DIR];
    assign port_dir.g = store[`OFS_PORT_G_DIR][4:0];
    assign port_out.a = store[`OFS_PORT_A_OUT];
    assign port_out.b = store[`OFS_PORT_B_OUT];
    assign port_out.c = store[`OFS_PORT_C_OUT];
    assign port_out.d = store[`OFS_PORT_D_OUT];
    assign port_out.e = store[`OFS_PORT_E_OUT];
    assign port_out.f = store[`OFS_PORT_F_OUT];
    assign port_out.g = store[`OFS_PORT_G_OUT][4:0];

    assign ctrl.timer0_event_flags = store[`OFS_TIMER0_FLAGS];
    assign ctrl.timer1_event_flags = store[`OFS_TIMER1_FLAGS];
    assign ctrl.timer2_event_flags = store[`OFS_TIMER2_FLAGS];
    assign ctrl.external_interrupt_flags = store[`OFS_EXT_INT_FLAGS];
    assign ctrl.external_interrupt_mask = store[`OFS_EXT_INT_MASK];
    assign ctrl.eeprom_control = store[`OFS_EEPROM_CTRL];
    assign ctrl.eeprom_data = store[`OFS_EEPROM_DATA];
    assign ctrl.eeprom_address_low = store[`OFS_EEPROM_ADDR_LO];
    assign ctrl.eeprom_address_high = store[`OFS_EEPROM_ADDR_HI];
    assign ctrl.timer_prescaler_control = store[`OFS_PRESCALER_CTRL];
    assign ctrl.timer0_control = store[`OFS_TIMER0_CTRL];
    assign ctrl.timer0_count = store[`OFS_TIMER0_COUNT];
    assign ctrl.timer0_compare_value = store[`OFS_TIMER0_COMPARE];
    assign ctrl.serial_peripheral_control = store[`OFS_SPI_CTRL];
    assign ctrl.serial_peripheral_status = store[`OFS_SPI_STATUS];

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence data_read_s;
        req.valid && req.data_space && req.op == io_space_pkg::op_read;
    endsequence

    sequence flag_write_s;
        req.valid && !req.data_space && req.op == io_space_pkg::op_write
            && req.addr == {2'b00, `OFS_TIMER0_FLAGS} && req.wdata[0]
            && !flag_set.timer0[0];
    endsequence

    // One I/O instruction of a given kind at a given offset
    sequence io_op_s(io_space_pkg::io_op_t o, logic [7:0] a);
        req.valid && !req.data_space && req.op == o && req.addr == a;
    endsequence

    data_alias_a: assert property (data_read_s |=> rsp.valid
        && rsp.hit == ($past(req.addr) >= 8'h20 && $past(req.addr) <= 8'h5F))
        else $error("data-space alias window wrong");

    ext_region_a: assert property (req.valid && !req.data_space |=> !rsp.ext_hit)
        else $error("extended region reached by I/O instruction");

    io_window_a: assert property (req.valid && !req.data_space && req.addr > 8'h3F
        |=> rsp.refused && !rsp.hit)
        else $error("I/O access beyond 64 locations accepted");

    bit_range_a: assert property (req.valid && !req.data_space && bit_op
        && req.addr > 8'h1F |=> rsp.refused)
        else $error("bit operation above 0x1F accepted");

    set_bit_a: assert property (req.valid && !req.data_space
        && req.op == io_space_pkg::set_single_bit_instr
        && req.addr == {2'b00, `OFS_PORT_C_OUT}
        |=> store[`OFS_PORT_C_OUT] == ($past(store[`OFS_PORT_C_OUT]) | $past(bit_m)))
        else $error("single-bit set changed wrong bits");

    skip_bit_a: assert property (take && req.op == io_space_pkg::skip_if_bit_one_instr
        |=> rsp.skip == |($past(cur) & $past(bit_m)))
        else $error("skip result does not follow tested bit");

    flag_clear_a: assert property (flag_write_s |=> !store[`OFS_TIMER0_FLAGS][0])
        else $error("write one did not clear flag");

    flag_keep_a: assert property (take && req.op == io_space_pkg::set_single_bit_instr
        && ofs == `OFS_TIMER1_FLAGS && flag_set.timer1 == 8'h00 |=> (store[`OFS_TIMER1_FLAGS]
        & ~$past(bit_m)) == ($past(store[`OFS_TIMER1_FLAGS]) & ~$past(bit_m)))
        else $error("bit operation disturbed another flag");

    reserved_read_a: assert property (req.valid && !req.data_space
        && req.op == io_space_pkg::op_read && req.addr == 8'h25
        ##1 rsp.valid |-> rsp.rdata == 8'h00)
        else $error("reserved offset read non-zero");

    rsp_pulse_a: assert property (rsp.valid == $past(req.valid))
        else $error("response pulse does not follow request");

    rsp_idle_a: assert property (!req.valid |=> !rsp.hit && !rsp.refused && !rsp.skip)
        else $error("response flags without a request");

    refused_hit_a: assert property (rsp.refused |-> !rsp.hit && !rsp.skip
        && rsp.rdata == 8'h00)
        else $error("refused access reported as hit");

    // An I/O instruction beyond offset 0x3F must leave the pads alone
    refused_keep_a: assert property (req.valid && !req.data_space && req.addr > 8'h3F
        |=> $stable(port_out) && $stable(port_dir))
        else $error("refused access changed a port");

    ext_sel_a: assert property (ext_sel |-> req.data_space && req.addr >= 8'h60)
        else $error("extended select outside data space");

    io_hit_a: assert property (req.valid && !req.data_space && req.addr <= 8'h3F
        && req.op inside {io_space_pkg::op_read, io_space_pkg::op_write}
        |=> rsp.hit && !rsp.refused)
        else $error("I/O access inside window not taken");

    low_bit_a: assert property (req.valid && !req.data_space && bit_op && req.addr <= 8'h1F
        |=> rsp.hit && !rsp.refused)
        else $error("bit operation on low offset refused");

    data_bit_a: assert property (req.valid && req.data_space && bit_op
        |=> rsp.refused && !rsp.hit)
        else $error("bit operation from data space accepted");

    clear_bit_a: assert property (io_op_s(io_space_pkg::clear_single_bit_instr,
        {2'b00, `OFS_PORT_C_OUT}) |=> store[`OFS_PORT_C_OUT]
        == ($past(store[`OFS_PORT_C_OUT]) & ~$past(bit_m)))
        else $error("single-bit clear changed wrong bits");

    skip_zero_a: assert property (io_op_s(io_space_pkg::skip_if_bit_zero_instr,
        {2'b00, `OFS_PORT_B_PINS}) |=> rsp.skip
        == ~|($past(pins.b) & (8'h01 << $past(req.bit_sel))))
        else $error("skip on zero does not follow pin");

    // Hardware set and software clear in one cycle: the set is kept
    set_wins_a: assert property (io_op_s(io_space_pkg::op_write,
        {2'b00, `OFS_TIMER0_FLAGS}) ##0 (req.wdata[0] && flag_set.timer0[0])
        |=> store[`OFS_TIMER0_FLAGS][0])
        else $error("flag event lost to a clearing write");

    flag_cbit_a: assert property (io_op_s(io_space_pkg::clear_single_bit_instr,
        {2'b00, `OFS_TIMER1_FLAGS}) ##0 (flag_set.timer1 == 8'h00)
        |=> $stable(store[`OFS_TIMER1_FLAGS]))
        else $error("single-bit clear disturbed a flag");

    pin_read_a: assert property (io_op_s(io_space_pkg::op_read, {2'b00, `OFS_PORT_C_PINS})
        |=> rsp.rdata == $past(pins.c))
        else $error("pin read does not show the pads");

    spi_status_a: assert property (io_op_s(io_space_pkg::op_read, {2'b00, `OFS_SPI_STATUS})
        |=> rsp.rdata[7:6] == $past(spi_hw_status) && rsp.rdata[5:1] == 5'h00)
        else $error("status read shows wrong bits");

    read_zero_a: assert property (req.valid && req.op != io_space_pkg::op_read
        |=> rsp.rdata == 8'h00)
        else $error("read data without a read");

    port_g_mask_a: assert property (store[`OFS_PORT_G_DIR][7:5] == 3'h0
        && store[`OFS_PORT_G_OUT][7:5] == 3'h0)
        else $error("port G holds unused bits");

    addr_hi_mask_a: assert property (store[`OFS_EEPROM_ADDR_HI][7:1] == 7'h00)
        else $error("address high holds unused bits");

    flag_mask_a: assert property ((store[`OFS_TIMER0_FLAGS]
        & ~`MASK_TIMER0_FLAGS) == 8'h00)
        else $error("timer flags hold unused bits");

endmodule

// ---- io_core_model.sv ----
`timescale 1ns/1ns

// ****************************************************************
// Processor core issuing I/O and load/store requests
// ****************************************************************
module io_core_model (
    input wire logic sys_clk,
    output io_space_pkg::io_req_t req,
    input wire io_space_pkg::io_rsp_t rsp,
    input wire logic ext_sel
);
    io_space_pkg::io_rsp_t last_rsp;
    logic last_ext_sel;

    initial begin
        req = '0;
        last_rsp = '0;
        last_ext_sel = 1'b0;
    end

    // One request per call, answer taken 1 ns after the edge that takes the request
    task automatic access(input logic ds, input io_space_pkg::io_op_t op,
                          input logic [7:0] addr, input logic [2:0] bit_sel,
                          input logic [7:0] wdata);
        @(posedge sys_clk);
        req <= '{valid: 1'b1, data_space: ds, op: op, addr: addr, bit_sel: bit_sel,
                 wdata: wdata};
        #1;
        last_ext_sel = ext_sel;
        @(posedge sys_clk);
        // Idle fields other than op flip so a design that samples them without valid is caught
        req <= '{valid: 1'b0, data_space: ~ds, op: op, addr: ~addr, bit_sel: ~bit_sel,
                 wdata: ~wdata};
        #1;
        last_rsp = rsp;
    endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ns

module tb_top;
    localparam io_space_pkg::io_op_t RD = io_space_pkg::op_read;
    localparam io_space_pkg::io_op_t WR = io_space_pkg::op_write;
    localparam io_space_pkg::io_op_t SB = io_space_pkg::set_single_bit_instr;
    localparam io_space_pkg::io_op_t CB = io_space_pkg::clear_single_bit_instr;
    localparam io_space_pkg::io_op_t S1 = io_space_pkg::skip_if_bit_one_instr;
    localparam io_space_pkg::io_op_t S0 = io_space_pkg::skip_if_bit_zero_instr;
    logic sys_clk;
    logic rst;
    io_space_pkg::io_req_t req;
    io_space_pkg::io_rsp_t rsp;
    logic ext_sel;
    io_space_pkg::port_bus_t pins;
    io_space_pkg::flag_event_t flag_set;
    logic [1:0] spi_hw_status;
    io_space_pkg::port_bus_t port_dir;
    io_space_pkg::port_bus_t port_out;
    io_space_pkg::periph_ctrl_t ctrl;
    io_space_pkg::periph_ctrl_t saved;
    int n_mismatch;
    int checked;
    int cycles;

    io_register_space_decoder io_register_space_decoder_inst (
        .sys_clk(sys_clk), .rst(rst), .req(req), .rsp(rsp), .ext_sel(ext_sel),
        .pins(pins), .flag_set(flag_set), .spi_hw_status(spi_hw_status),
        .port_dir(port_dir), .port_out(port_out), .ctrl(ctrl)
    );

    io_core_model io_core_model_inst (
        .sys_clk(sys_clk), .req(req), .rsp(rsp), .ext_sel(ext_sel)
    );

    initial begin
        sys_clk = 1'b0;
    end
    always #4 sys_clk = ~sys_clk;

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Long enough for every scenario, short enough to cut a stalled run
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic op(input logic ds, input io_space_pkg::io_op_t o, input logic [7:0] addr,
                      input logic [2:0] b, input logic [7:0] wd);
        io_core_model_inst.access(ds, o, addr, b, wd);
    endtask

    task automatic rd(input logic ds, input logic [7:0] addr, input logic [7:0] exp);
        io_core_model_inst.access(ds, RD, addr, 3'd0, 8'h00);
        check($sformatf("rdata at %h", addr), io_core_model_inst.last_rsp.rdata, exp);
    endtask

    task automatic chk_rsp(input string name, input logic hit, input logic refused);
        check({name, " hit"}, {7'b0, io_core_model_inst.last_rsp.hit}, {7'b0, hit});
        check({name, " refused"}, {7'b0, io_core_model_inst.last_rsp.refused}, {7'b0, refused});
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        check("ctrl after reset", 8'(ctrl != '0), 8'h00);
        check("port_dir after reset", 8'(port_dir != '0), 8'h00);
        check("port_out after reset", 8'(port_out != '0), 8'h00);
    endtask

    task automatic t_window();
        // Both windows reach the same registers; the extended bank takes data space only
        op(1'b0, WR, 8'h05, 3'd0, 8'h5A);
        check("port_out.b", port_out.b, 8'h5A);
        rd(1'b1, 8'h25, 8'h5A);
        op(1'b1, WR, 8'h41, 3'd0, 8'hA5);
        check("eeprom_address_low", ctrl.eeprom_address_low, 8'hA5);
        rd(1'b0, 8'h21, 8'hA5);
        rd(1'b0, 8'h06, 8'h3C);
        op(1'b1, RD, 8'h1F, 3'd0, 8'h00);
        chk_rsp("data below window", 1'b0, 1'b0);
        op(1'b0, RD, 8'h40, 3'd0, 8'h00);
        chk_rsp("io beyond 64", 1'b0, 1'b1);
        op(1'b1, WR, 8'h60, 3'd0, 8'hFF);
        check("ext_hit 0x60", {7'b0, io_core_model_inst.last_rsp.ext_hit}, 8'h01);
        check("ext_sel 0x60", {7'b0, io_core_model_inst.last_ext_sel}, 8'h01);
        chk_rsp("ext data", 1'b0, 1'b0);
        op(1'b1, RD, 8'hFF, 3'd0, 8'h00);
        check("ext_hit 0xff", {7'b0, io_core_model_inst.last_rsp.ext_hit}, 8'h01);
        op(1'b0, WR, 8'h60, 3'd0, 8'hFF);
        check("ext_sel io", {7'b0, io_core_model_inst.last_ext_sel}, 8'h00);
        chk_rsp("ext by io", 1'b0, 1'b1);
    endtask

    task automatic t_bits();
        op(1'b0, WR, 8'h08, 3'd0, 8'h81);
        op(1'b0, SB, 8'h08, 3'd3, 8'h00);
        check("set bit 3", port_out.c, 8'h89);
        op(1'b0, CB, 8'h08, 3'd7, 8'h00);
        check("clear bit 7", port_out.c, 8'h09);
        op(1'b0, SB, 8'h20, 3'd0, 8'h00);
        chk_rsp("bit op 0x20", 1'b0, 1'b1);
        op(1'b1, SB, 8'h28, 3'd1, 8'h00);
        chk_rsp("bit op data space", 1'b0, 1'b1);
        check("port_out.c kept", port_out.c, 8'h09);
        @(posedge sys_clk);
        flag_set.timer1 <= 8'hFF;
        @(posedge sys_clk);
        flag_set.timer1 <= 8'h00;
        rd(1'b0, 8'h16, 8'h27);
        op(1'b0, SB, 8'h16, 3'd1, 8'h00);
        rd(1'b0, 8'h16, 8'h25);
        op(1'b0, CB, 8'h16, 3'd0, 8'h00);
        rd(1'b0, 8'h16, 8'h25);
        op(1'b0, WR, 8'h16, 3'd0, 8'h04);
        rd(1'b0, 8'h16, 8'h21);
        op(1'b0, WR, 8'h16, 3'd0, 8'h00);
        rd(1'b0, 8'h16, 8'h21);
    endtask

    task automatic t_skip();
        io_space_pkg::io_op_t ops[4] = '{S1, S1, S0, S0};
        logic [2:0] bits[4] = '{3'd7, 3'd6, 3'd6, 3'd7};
        logic [7:0] exp[4] = '{8'h01, 8'h00, 8'h01, 8'h00};
        for (int i = 0; i < 4; i++) begin
            op(1'b0, ops[i], 8'h03, bits[i], 8'h00);
            check("skip", {7'b0, io_core_model_inst.last_rsp.skip}, exp[i]);
        end
        op(1'b0, S1, 8'h20, 3'd0, 8'h00);
        chk_rsp("skip 0x20", 1'b0, 1'b1);
        op(1'b1, S0, 8'h23, 3'd7, 8'h00);
        chk_rsp("skip data space", 1'b0, 1'b1);
    endtask

    task automatic t_reserved();
        saved = ctrl;
        op(1'b0, WR, 8'h25, 3'd0, 8'hFF);
        rd(1'b0, 8'h25, 8'h00);
        check("ctrl kept", 8'(ctrl != saved), 8'h00);
        op(1'b0, WR, 8'h13, 3'd0, 8'hFF);
        check("port_dir.g", {3'b0, port_dir.g}, 8'h1F);
        rd(1'b0, 8'h13, 8'h1F);
        op(1'b0, WR, 8'h2D, 3'd0, 8'hFF);
        rd(1'b0, 8'h2D, 8'h81);
        op(1'b0, WR, 8'h22, 3'd0, 8'hFF);
        rd(1'b0, 8'h22, 8'h01);
        op(1'b0, WR, 8'h15, 3'd0, 8'h00);
        @(posedge sys_clk);
        flag_set.timer0 <= 8'hFF;
        @(posedge sys_clk);
        flag_set.timer0 <= 8'h00;
        rd(1'b0, 8'h15, 8'h03);
        op(1'b0, WR, 8'h15, 3'd0, 8'h01);
        rd(1'b0, 8'h15, 8'h02);
        // Event and clearing write meet at the same edge
        fork
            op(1'b0, WR, 8'h15, 3'd0, 8'h01);
            begin
                @(posedge sys_clk);
                flag_set.timer0 <= 8'h01;
                @(posedge sys_clk);
                flag_set.timer0 <= 8'h00;
            end
        join
        rd(1'b0, 8'h15, 8'h03);
    endtask

    initial begin
        rst = 1'b1;
        cycles = 0;
        n_mismatch = 0;
        checked = 0;
        pins = '0;
        pins.b = 8'h80;
        pins.c = 8'h3C;
        flag_set = '0;
        spi_hw_status = 2'b10;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        t_reset();
        t_window();
        t_bits();
        t_skip();
        t_reserved();
        close_out();
    end
endmodule
